// ---- mfm_defines.vh ----
// Purpose: Constants for the mast fault monitor
// Assumes: 125 MHz clock
// Notes: Fault codes are BCD-like hex digit weights that add without carry
`ifndef MFM_DEFINES_VH
`define MFM_DEFINES_VH
`define MFM_CLK_HZ 125000000
`define MFM_TICK_HZ 1000
`define MFM_TICK_DIV (`MFM_CLK_HZ / `MFM_TICK_HZ)
`define MFM_LIMIT_STUCK_MS 2000
`define MFM_BYPASS_WINDOW_MS 3000
`define MFM_BYPASS_STUCK_MS 30000
`define MFM_SWITCH_STUCK_MS 30000
`define MFM_BYPASS_PRESSES 5
`define MFM_CODE_LOWV 16'h0001
`define MFM_CODE_OVERCUR 16'h0002
`define MFM_CODE_LOW_STUCK 16'h0040
`define MFM_CODE_UP_STUCK 16'h0080
`define MFM_CODE_BYP_STUCK 16'h0100
`define MFM_CODE_LIM_CONFLICT 16'h0200
`define MFM_CODE_TX_OVF 16'h1000
`define MFM_CODE_RX_OVF 16'h2000
`define MFM_CODE_CMD_ERR 16'h8000
`endif

// ---- mfm_press_log.v ----
// Purpose: Small memory of bypass press timestamps for the sliding window
// Assumes: One write per press; read data registered
// Notes: Depth equals the number of presses needed to clear
`timescale 1ns/1ps
`default_nettype none
module mfm_press_log #(
  parameter DEPTH = 5,
  parameter AW = 3,
  parameter DW = 16
) (
  // Clock
  input wire clk,
  // Write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read side
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ---- mfm_fault_monitor.v ----
// Purpose: Fault supervision for a telescoping mast motor controller
// Assumes: Switch inputs are asynchronous pins; CAN and debug events are same-clock pulses
// Notes: Power cycle is modelled as rstn; faults re-raise if triggers persist
`timescale 1ns/1ps
`default_nettype none
`include "mfm_defines.vh"

// Summary of operation
// - Nested, up held over 2s: fault 0040
// - Lower stuck fault disables motor unless bypass
// - Lower stuck combines with voltage/current codes
// - Deployed, down held over 2s: fault 0080
// - Upper stuck combines with voltage/current codes
// - Limit faults clear: five presses in 3s
// - Bypass held too long: 0100, ignore bypass
// - Bypass stuck clears on release only
// - Both limits active: 0200, disable unless bypass
// - Conflict fault clears when either limit drops
// - Transmit write while queue busy: 1000
// - Receive overwrite before retrieve: 2000
// - Debug bad command: 8000, clears by presses
// - Legacy both-limit error, bypass allows motor
// - Legacy error persists while condition persists
// - Active faults sum into one code
// - Warnings hidden while any fault active
module mfm_fault_monitor #(
  parameter TICK_DIV = `MFM_TICK_DIV,
  parameter LIMIT_STUCK_MS = `MFM_LIMIT_STUCK_MS,
  parameter BYPASS_WINDOW_MS = `MFM_BYPASS_WINDOW_MS,
  parameter BYPASS_STUCK_MS = `MFM_BYPASS_STUCK_MS
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Operator and limit switches (asynchronous)
  input wire up_cmd,
  input wire down_cmd,
  input wire bypass_sw,
  input wire nested_limit,
  input wire extended_limit,
  // Faults and warnings from neighbouring logic
  input wire low_volt_fault,
  input wire overcur_fault,
  input wire [15:0] warn_code,
  // CAN buffer and debug events (same clock)
  input wire can_tx_write,
  input wire can_tx_busy,
  input wire can_rx_write,
  input wire can_rx_full,
  input wire dbg_bad_cmd,
  // Outputs
  output reg motor_enable,
  output reg [15:0] status_code,
  output reg fault_active,
  output reg can_bus_fail,
  output reg legacy_limit_err
);
  // Synchronisers
  reg [4:0] sync1;
  reg [4:0] sync2;

  always @(posedge clk) begin
    if (!rstn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {extended_limit, nested_limit, bypass_sw, down_cmd, up_cmd};
      sync2 <= sync1;
    end
  end
  wire up_s = sync2[0];
  wire down_s = sync2[1];
  wire byp_s = sync2[2];
  wire nest_s = sync2[3];
  wire ext_s = sync2[4];

  // Millisecond timebase and free running ms stamp
  // Every timer below counts these ticks, so this divider sets their resolution
  reg [16:0] div_cnt;
  reg tick;
  reg [15:0] now_ms;
  always @(posedge clk) begin
    if (!rstn) begin
      div_cnt <= 17'h00000;
      tick <= 1'b0;
      now_ms <= 16'h0000;
    end else if (div_cnt >= TICK_DIV - 1) begin
      div_cnt <= 17'h00000;
      tick <= 1'b1;
      now_ms <= now_ms + 16'h0001;
    end else begin
      div_cnt <= div_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // Saturating ms timer step
  // Saturation keeps a held switch from wrapping back under its limit
  function [15:0] ms_step;
    input run;
    input tk;
    input [15:0] cur;
    begin
      if (!run) begin
        ms_step = 16'h0000;
      end else if (tk && cur != 16'hFFFF) begin
        ms_step = cur + 16'h0001;
      end else begin
        ms_step = cur;
      end
    end
  endfunction

  reg [15:0] low_ms;
  reg [15:0] up_ms;
  reg [15:0] byp_ms;
  reg nest_prev;
  reg ext_prev;
  reg byp_prev;
  reg low_arm;
  reg up_arm;

  // Lower stuck: up held from nested with no nested-limit change
  wire low_run = up_s && low_arm && nest_s && (nest_s == nest_prev);
  wire up_run = down_s && up_arm && ext_s && (ext_s == ext_prev);
  always @(posedge clk) begin
    if (!rstn) begin
      low_ms <= 16'h0000;
      up_ms <= 16'h0000;
      byp_ms <= 16'h0000;
      nest_prev <= 1'b0;
      ext_prev <= 1'b0;
      byp_prev <= 1'b0;
      low_arm <= 1'b0;
      up_arm <= 1'b0;
    end else begin
      nest_prev <= nest_s;
      ext_prev <= ext_s;
      byp_prev <= byp_s;
      // Arm on any cycle the command is held while resting at the limit
      low_arm <= up_s ? (low_arm | (!low_arm && low_ms == 16'h0000 && nest_s)) : 1'b0;
      up_arm <= down_s ? (up_arm | (!up_arm && up_ms == 16'h0000 && ext_s)) : 1'b0;
      low_ms <= ms_step(low_run, tick, low_ms);
      up_ms <= ms_step(up_run, tick, up_ms);
      byp_ms <= ms_step(byp_s, tick, byp_ms);
    end
  end

  // Sliding window of bypass press timestamps
  localparam PRESSES = `MFM_BYPASS_PRESSES;
  reg [2:0] wr_ptr;
  reg [2:0] press_cnt;
  wire byp_stuck_w;
  wire byp_eff = byp_s && !byp_stuck_w;
  // A stuck switch produces no edges, so it can never count toward a clear
  wire press = byp_s && !byp_prev && !byp_stuck_w;
  wire [15:0] oldest_ms;
  reg clear_seq;
  reg chk;
  // Read one slot ahead of the write, so the registered read holds the
  // oldest of the last five presses rather than the slot being overwritten
  wire [2:0] next_ptr = (wr_ptr == PRESSES - 1) ? 3'h0 : wr_ptr + 3'h1;
  // Span kept at 16 bits so the ms stamp may wrap between presses
  wire [15:0] win_span = now_ms - oldest_ms;

  mfm_press_log #(
    .DEPTH(PRESSES),
    .AW(3),
    .DW(16)
  ) u_log (
    .clk(clk),
    .wr_en(press),
    .wr_addr(wr_ptr),
    .wr_data(now_ms),
    .rd_addr(next_ptr),
    .rd_data(oldest_ms)
  );

  // One cycle after a press, the registered read holds the oldest of the last five
  always @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= 3'h0;
      press_cnt <= 3'h0;
      chk <= 1'b0;
      clear_seq <= 1'b0;
    end else begin
      chk <= press;
      clear_seq <= 1'b0;
      if (press) begin
        wr_ptr <= next_ptr;
        // Stops at five; older presses only matter through their stamps
        if (press_cnt != PRESSES) begin
          press_cnt <= press_cnt + 3'h1;
        end
      end
      if (chk && press_cnt == PRESSES &&
          win_span <= BYPASS_WINDOW_MS) begin
        clear_seq <= 1'b1;
        press_cnt <= 3'h0;
      end
    end
  end

  // Fault latches
  reg f_low;
  reg f_up;
  reg f_byp;
  reg f_conf;
  reg f_tx;
  reg f_rx;
  reg f_cmd;
  assign byp_stuck_w = f_byp;
  // Physically impossible, so it always means a switch or wiring fault
  wire both_lim = nest_s && ext_s;
  wire set_low = low_ms >= LIMIT_STUCK_MS && low_ms != 16'h0000;
  wire set_up = up_ms >= LIMIT_STUCK_MS && up_ms != 16'h0000;

  always @(posedge clk) begin
    if (!rstn) begin
      f_low <= 1'b0;
      f_up <= 1'b0;
      f_byp <= 1'b0;
      f_conf <= 1'b0;
      f_tx <= 1'b0;
      f_rx <= 1'b0;
      f_cmd <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      if (set_low) begin
        f_low <= 1'b1;
      end else if (clear_seq) begin
        f_low <= 1'b0;
      end
      if (set_up) begin
        f_up <= 1'b1;
      end else if (clear_seq) begin
        f_up <= 1'b0;
      end
      // Only releasing the switch clears this; a press cannot mask it
      if (byp_s && byp_ms >= BYPASS_STUCK_MS) begin
        f_byp <= 1'b1;
      end else if (!byp_s) begin
        f_byp <= 1'b0;
      end
      // Tracks the limits with no latch, so it drops with either switch
      f_conf <= both_lim;
      // No clear path here: only reset removes the CAN faults
      if (can_tx_write && can_tx_busy) begin
        f_tx <= 1'b1;
      end
      if (can_rx_write && can_rx_full) begin
        f_rx <= 1'b1;
      end
      if (dbg_bad_cmd) begin
        f_cmd <= 1'b1;
      end else if (clear_seq) begin
        f_cmd <= 1'b0;
      end
    end
  end

  // Code composition; each fault owns its own bit weight
  reg [15:0] next_code;
  reg next_fault;

  always @* begin
    next_code = 16'h0000;
    if (low_volt_fault) next_code = next_code | `MFM_CODE_LOWV;
    if (overcur_fault) next_code = next_code | `MFM_CODE_OVERCUR;
    if (f_low) next_code = next_code | `MFM_CODE_LOW_STUCK;
    if (f_up) next_code = next_code | `MFM_CODE_UP_STUCK;
    if (f_byp) next_code = next_code | `MFM_CODE_BYP_STUCK;
    if (f_conf) next_code = next_code | `MFM_CODE_LIM_CONFLICT;
    if (f_tx) next_code = next_code | `MFM_CODE_TX_OVF;
    if (f_rx) next_code = next_code | `MFM_CODE_RX_OVF;
    if (f_cmd) next_code = next_code | `MFM_CODE_CMD_ERR;
    next_fault = next_code != 16'h0000;
  end

  // Faults that stop the motor; the bypass switch overrides all of them unless it is itself stuck
  wire motor_block = f_low || f_up || both_lim;

  // Registered outputs
  always @(posedge clk) begin
    if (!rstn) begin
      motor_enable <= 1'b0;
      status_code <= 16'h0000;
      fault_active <= 1'b0;
      can_bus_fail <= 1'b0;
      legacy_limit_err <= 1'b0;
    end else begin
      status_code <= next_fault ? next_code : warn_code;
      fault_active <= next_fault;
      can_bus_fail <= f_tx | f_rx;
      legacy_limit_err <= both_lim;
      // Bypass re-enables the motor only when it is not itself stuck
      motor_enable <= !motor_block || byp_eff;
    end
  end
endmodule
`default_nettype wire

// ---- mfm_can_peer.sv ----
// Purpose: CAN buffer side model seen by the fault monitor
// Assumes: Same clock as the monitor
// Notes: Received frames are never retrieved, so a second frame overflows
`timescale 1ns/1ps
`default_nettype none
module mfm_can_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Transmit queue
  input wire logic can_tx_write,
  output wire logic can_tx_busy,
  // Receive buffer
  input wire logic rx_send,
  output wire logic can_rx_write,
  output logic can_rx_full
);
  logic [3:0] drain;
  // Queue stays busy while a frame drains onto the bus
  assign can_tx_busy = (drain != 4'h0);
  assign can_rx_write = rx_send;
  always @(posedge clk) begin
    if (!rstn) begin
      drain <= 4'h0;
      can_rx_full <= 1'b0;
    end else begin
      drain <= can_tx_write ? 4'hF : drain - {3'h0, can_tx_busy};
      if (can_rx_write) can_rx_full <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- mfm_chk.sv ----
// Purpose: Port-level checks of the mast fault monitor
// Assumes: Switches pass two sync flops, so windows allow a few cycles
// Notes: Long timers are left to the bench
`timescale 1ns/1ps
`default_nettype none
module mfm_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic bypass_sw,
  input wire logic nested_limit,
  input wire logic extended_limit,
  input wire logic [15:0] warn_code,
  input wire logic can_tx_write,
  input wire logic can_tx_busy,
  input wire logic can_rx_write,
  input wire logic can_rx_full,
  input wire logic dbg_bad_cmd,
  // Outputs watched
  input wire logic motor_enable,
  input wire logic [15:0] status_code,
  input wire logic fault_active,
  input wire logic can_bus_fail,
  input wire logic legacy_limit_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tx_overflow: assert property (can_tx_write && can_tx_busy |-> ##[1:2] status_code[12])
    else $error("Transmit overflow not flagged");
  a_rx_overflow: assert property (can_rx_write && can_rx_full |-> ##[1:2] status_code[13])
    else $error("Receive overflow not flagged");
  a_can_latched: assert property (can_bus_fail |=> can_bus_fail && status_code[13:12] != 2'b00)
    else $error("CAN fault dropped before reset");
  a_dbg_error: assert property (dbg_bad_cmd |-> ##[1:2] status_code[15])
    else $error("Bad debug command not flagged");
  a_conflict_set: assert property ((nested_limit && extended_limit) [*6] |-> status_code[9] && legacy_limit_err)
    else $error("Limit conflict not flagged");
  a_conflict_clear: assert property ((!nested_limit || !extended_limit) [*6] |->
    !(fault_active && status_code[9]) && !legacy_limit_err)
    else $error("Limit conflict held after a limit dropped");
  a_motor_gated: assert property ((fault_active && (status_code[6] || status_code[7] || status_code[9])
    && !bypass_sw) [*6] |-> !motor_enable)
    else $error("Motor left enabled under fault");
  a_bypass_ignored: assert property ((fault_active && status_code[8] && status_code[9] && legacy_limit_err)
    [*4] |-> !motor_enable)
    else $error("Stuck bypass still enabled motor");
  a_bypass_release: assert property (!bypass_sw [*6] |-> !(fault_active && status_code[8]))
    else $error("Bypass stuck fault held after release");
  a_warn_shown: assert property ((!fault_active && $stable(warn_code)) [*3] |-> status_code == warn_code)
    else $error("Warning code not shown when fault free");
  c_low_volt_combo: cover property (status_code == 16'h0041);
  c_stuck_conflict: cover property (status_code[8] && status_code[9]);
  c_can_fail: cover property (can_bus_fail);
endmodule
bind mfm_fault_monitor mfm_chk u_chk (.clk, .rstn, .bypass_sw, .nested_limit, .extended_limit,
  .warn_code, .can_tx_write, .can_tx_busy, .can_rx_write, .can_rx_full, .dbg_bad_cmd,
  .motor_enable, .status_code, .fault_active, .can_bus_fail, .legacy_limit_err);
`default_nettype wire

// ---- mfm_fault_monitor_tb_top.sv ----
// Purpose: Self-checking bench for the mast fault monitor
// Assumes: Short timer parameters: 10-cycle ms tick
// Notes: Status expectations go through a queue to a monitor process
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_monitor_tb_top;
  logic clk = 0, rstn = 0, up_cmd = 0, down_cmd = 0, bypass_sw = 0, nested_limit = 0;
  logic extended_limit = 0, low_volt_fault = 0, overcur_fault = 0, can_tx_write = 0;
  logic rx_send = 0, dbg_bad_cmd = 0;
  logic [15:0] warn_code = 16'h0000;
  wire can_tx_busy, can_rx_write, can_rx_full, motor_enable, fault_active, can_bus_fail, legacy_limit_err;
  wire [15:0] status_code;
  logic [15:0] exp_q[$];
  event look;
  int err_total = 0, n_checks = 0, cyc = 0;
  mfm_fault_monitor #(.TICK_DIV(10), .LIMIT_STUCK_MS(5), .BYPASS_WINDOW_MS(8),
    .BYPASS_STUCK_MS(20)) DUT (.clk(clk), .rstn(rstn), .up_cmd(up_cmd), .down_cmd(down_cmd),
    .bypass_sw(bypass_sw), .nested_limit(nested_limit), .extended_limit(extended_limit),
    .low_volt_fault(low_volt_fault), .overcur_fault(overcur_fault), .warn_code(warn_code),
    .can_tx_write(can_tx_write), .can_tx_busy(can_tx_busy), .can_rx_write(can_rx_write),
    .can_rx_full(can_rx_full), .dbg_bad_cmd(dbg_bad_cmd), .motor_enable(motor_enable),
    .status_code(status_code), .fault_active(fault_active), .can_bus_fail(can_bus_fail),
    .legacy_limit_err(legacy_limit_err));
  mfm_can_peer peer (.clk(clk), .rstn(rstn), .can_tx_write(can_tx_write),
    .can_tx_busy(can_tx_busy), .rx_send(rx_send), .can_rx_write(can_rx_write),
    .can_rx_full(can_rx_full));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic expect_code(input logic [15:0] v);
    exp_q.push_back(v);
    -> look;
    #1;
  endtask
  task automatic do_reset;
    rstn = 0;
    ticks(16);
    rstn = 1;
    warn_code = 16'($urandom);
    ticks(6);
  endtask
  // Five presses spread over 40 cycles sit inside the 80-cycle window
  task automatic presses;
    repeat (5) begin
      bypass_sw = 1;
      ticks(4);
      bypass_sw = 0;
      ticks(4);
    end
    ticks(6);
  endtask
  always @(look) chk("status_code", status_code, exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(32'h33D98C9C));
    do_reset;
    expect_code(warn_code);
    chk("motor_enable", 16'(motor_enable), 16'h0001);
    nested_limit = 1;
    ticks(6);
    up_cmd = 1;
    ticks(70);
    expect_code(16'h0040);
    chk("fault_active", 16'(fault_active), 16'h0001);
    chk("motor_enable", 16'(motor_enable), 16'h0000);
    bypass_sw = 1;
    ticks(6);
    chk("motor_enable", 16'(motor_enable), 16'h0001);
    bypass_sw = 0;
    low_volt_fault = 1;
    ticks(6);
    expect_code(16'h0041);
    low_volt_fault = 0;
    up_cmd = 0;
    presses;
    expect_code(warn_code);
    $display("Test lower stuck done");
    nested_limit = 0;
    extended_limit = 1;
    ticks(6);
    down_cmd = 1;
    ticks(70);
    overcur_fault = 1;
    ticks(6);
    expect_code(16'h0082);
    overcur_fault = 0;
    down_cmd = 0;
    dbg_bad_cmd = 1;
    ticks(1);
    dbg_bad_cmd = 0;
    ticks(4);
    expect_code(16'h8080);
    presses;
    expect_code(warn_code);
    $display("Test upper stuck done");
    nested_limit = 1;
    ticks(8);
    expect_code(16'h0200);
    chk("legacy_limit_err", 16'(legacy_limit_err), 16'h0001);
    chk("motor_enable", 16'(motor_enable), 16'h0000);
    bypass_sw = 1;
    ticks(6);
    chk("motor_enable", 16'(motor_enable), 16'h0001);
    bypass_sw = 0;
    extended_limit = 0;
    ticks(8);
    expect_code(warn_code);
    chk("fault_active", 16'(fault_active), 16'h0000);
    chk("legacy_limit_err", 16'(legacy_limit_err), 16'h0000);
    $display("Test conflict done");
    bypass_sw = 1;
    ticks(230);
    extended_limit = 1;
    ticks(8);
    expect_code(16'h0300);
    chk("motor_enable", 16'(motor_enable), 16'h0000);
    extended_limit = 0;
    bypass_sw = 0;
    ticks(8);
    expect_code(warn_code);
    $display("Test bypass stuck done");
    can_tx_write = 1;
    ticks(2);
    can_tx_write = 0;
    ticks(3);
    expect_code(16'h1000);
    chk("can_bus_fail", 16'(can_bus_fail), 16'h0001);
    rx_send = 1;
    ticks(2);
    rx_send = 0;
    ticks(3);
    presses;
    expect_code(16'h3000);
    do_reset;
    expect_code(warn_code);
    chk("can_bus_fail", 16'(can_bus_fail), 16'h0000);
    $display("Test CAN overflow done");
    wrap_up;
  end
endmodule
`default_nettype wire
